// *** logic/ebc_break_unit.v ***
// Purpose: Break detection, break cause and cycle measurement for the emulator.
// Assumes: One clock; core fetch stream synchronous to pclk; APB register access.
// Notes: Breakpoint and code memories are on-chip arrays, 8192 words each.
//
// Added by the designer: the APB register port and the address map.
`include "ebc_map.vh"
`default_nettype none
module ebc_break_unit (
    // APB slave.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Emulated core stream.
    input wire fetch_first,
    input wire [12:0] fetch_pc,
    input wire [12:0] next_pc,
    input wire halt_mode,
    input wire esc_req,
    input wire trace_overflow,
    input wire addr_match_brk,
    input wire addr_pass_brk,
    input wire data_pass_brk,
    input wire acc_pass_brk,
    // Emulation control.
    output wire emu_run,
    output wire emu_stop,
    output wire irq
);
    reg [31:0] ctrl_reg;
    reg [3:0] cause_reg;
    reg [12:0] start_reg;
    reg [12:0] stop_reg;
    reg [12:0] bp_addr_reg;
    reg [12:0] cm_addr_reg;
    reg [12:0] brk_pc_reg;
    reg [12:0] next_pc_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg [31:0] prdata_reg;
    reg stop_pulse_reg;
    reg run_d_reg;
    reg bp_mem [0:`EBC_CODE_WORDS-1];
    reg [7:0] code_mem [0:`EBC_CODE_WORDS-1];
    reg [13:0] fill_cnt_reg;
    reg fill_val_reg;
    reg [3:0] hit_cause;
    reg hit;
    wire [31:0] cyc_count;
    wire cyc_ovf;
    wire wr_en;
    wire rd_en;
    wire run_now;
    wire [12:0] top;
    wire filling;

    // Top of code space for the selected chip mode.
    function [12:0] mode_top;
        input [1:0] mode;
        begin
            if (mode == 2'd0)
                mode_top = `EBC_TOP_MODE0;
            else if (mode == 2'd1)
                mode_top = `EBC_TOP_MODE1;
            else
                mode_top = `EBC_TOP_MODE2;
        end
    endfunction

    // Address legality against the selected mode span.
    function in_span;
        input [12:0] a;
        input [1:0] mode;
        begin
            in_span = (a <= mode_top(mode));
        end
    endfunction

    assign top = mode_top(ctrl_reg[`EBC_CTRL_MODE_LO+1:`EBC_CTRL_MODE_LO]);
    assign run_now = ctrl_reg[`EBC_CTRL_RUN];
    assign emu_run = run_now;
    assign emu_stop = stop_pulse_reg;
    assign filling = (fill_cnt_reg != 14'h0000);
    // Zero-wait slave except while a breakpoint fill sweeps the memory.
    assign pready = !filling;
    assign wr_en = psel && penable && pwrite && !filling;
    assign rd_en = psel && !penable && !pwrite;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    ebc_cycle_counter u_cyc (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_now),
        .halt(halt_mode),
        .fetch(fetch_first),
        .fetch_addr(fetch_pc),
        .clear(run_now && !run_d_reg),
        .start_addr(start_reg),
        .stop_addr(stop_reg),
        .count_reg(cyc_count),
        .overflow_pulse(cyc_ovf)
    );

    // Break detection in priority order; the host escape wins over all.
    always @* begin
        hit = 1'b0;
        hit_cause = `EBC_CAUSE_NONE;
        if (run_now) begin
            if (esc_req) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_ESC;
            end else if (fetch_first && !in_span(fetch_pc,
                    ctrl_reg[`EBC_CTRL_MODE_LO+1:`EBC_CTRL_MODE_LO])) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_NAREA;
            end else if (fetch_first && ctrl_reg[`EBC_CTRL_EN_BP] && bp_mem[fetch_pc]) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_BP;
            end else if (trace_overflow && ctrl_reg[`EBC_CTRL_EN_TP]) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_TPOVF;
            end else if (cyc_ovf && ctrl_reg[`EBC_CTRL_EN_CC]) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_CCOVF;
            end else if (addr_match_brk) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_AMATCH;
            end else if (addr_pass_brk) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_APASS;
            end else if (data_pass_brk) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_DPASS;
            end else if (acc_pass_brk) begin
                hit = 1'b1;
                hit_cause = `EBC_CAUSE_BAPASS;
            end
        end
    end

    // Control, cause, capture and interrupt state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `EBC_CTRL_RESET;
            cause_reg <= `EBC_CAUSE_NONE;
            start_reg <= 13'h0000;
            stop_reg <= 13'h0000;
            bp_addr_reg <= 13'h0000;
            cm_addr_reg <= 13'h0000;
            brk_pc_reg <= 13'h0000;
            next_pc_reg <= 13'h0000;
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
            stop_pulse_reg <= 1'b0;
            run_d_reg <= 1'b0;
            fill_cnt_reg <= 14'h0000;
            fill_val_reg <= 1'b0;
        end else begin
            stop_pulse_reg <= 1'b0;
            run_d_reg <= run_now;
            if (filling)
                fill_cnt_reg <= fill_cnt_reg - 14'h0001;
            if (wr_en) begin
                if (paddr == `EBC_OFF_CTRL)
                    ctrl_reg <= pwdata & 32'h0000_0137;
                else if (paddr == `EBC_OFF_START)
                    start_reg <= pwdata[12:0];
                else if (paddr == `EBC_OFF_STOP)
                    stop_reg <= pwdata[12:0];
                else if (paddr == `EBC_OFF_BPADDR)
                    bp_addr_reg <= pwdata[12:0];
                else if (paddr == `EBC_OFF_CMADDR)
                    cm_addr_reg <= pwdata[12:0];
                else if (paddr == `EBC_OFF_IRQ_MASK)
                    irq_mask_reg <= pwdata[1:0];
                else if (paddr == `EBC_OFF_BPFILL) begin
                    fill_cnt_reg <= 14'h2000;
                    fill_val_reg <= pwdata[0];
                end
            end
            // A stop clears run and records cause and program counters.
            if (hit) begin
                ctrl_reg[`EBC_CTRL_RUN] <= 1'b0;
                cause_reg <= hit_cause;
                brk_pc_reg <= fetch_pc;
                next_pc_reg <= next_pc;
                stop_pulse_reg <= 1'b1;
            end
            // Sticky status: set wins over a write-one clear in the same cycle.
            irq_stat_reg <= (irq_stat_reg & ~((wr_en && paddr == `EBC_OFF_IRQ_STAT) ?
                pwdata[1:0] : 2'b00)) | {cyc_ovf, hit};
        end
    end

    // Breakpoint memory: single host write or a fill sweep; code memory: host write.
    always @(posedge pclk) begin
        if (filling)
            bp_mem[fill_cnt_reg[12:0] - 13'h0001] <= fill_val_reg;
        else if (wr_en && paddr == `EBC_OFF_BPDATA && in_span(bp_addr_reg,
                ctrl_reg[`EBC_CTRL_MODE_LO+1:`EBC_CTRL_MODE_LO]))
            bp_mem[bp_addr_reg] <= pwdata[0];
        if (wr_en && paddr == `EBC_OFF_CMDATA && cm_addr_reg <= top)
            code_mem[cm_addr_reg] <= pwdata[7:0];
    end

    // Read data is captured in the setup cycle so it is stable in access.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            if (paddr == `EBC_OFF_CTRL)
                prdata_reg <= ctrl_reg;
            else if (paddr == `EBC_OFF_CAUSE)
                prdata_reg <= {28'h0000000, cause_reg};
            else if (paddr == `EBC_OFF_CYC)
                prdata_reg <= cyc_count;
            else if (paddr == `EBC_OFF_START)
                prdata_reg <= {19'h00000, start_reg};
            else if (paddr == `EBC_OFF_STOP)
                prdata_reg <= {19'h00000, stop_reg};
            else if (paddr == `EBC_OFF_BPADDR)
                prdata_reg <= {19'h00000, bp_addr_reg};
            else if (paddr == `EBC_OFF_BPDATA)
                prdata_reg <= {31'h00000000, bp_mem[bp_addr_reg]};
            else if (paddr == `EBC_OFF_CMADDR)
                prdata_reg <= {19'h00000, cm_addr_reg};
            else if (paddr == `EBC_OFF_CMDATA)
                prdata_reg <= (cm_addr_reg <= top) ?
                    {24'h000000, code_mem[cm_addr_reg]} : 32'h0000_0000;
            else if (paddr == `EBC_OFF_BRKPC)
                prdata_reg <= {19'h00000, brk_pc_reg};
            else if (paddr == `EBC_OFF_NEXTPC)
                prdata_reg <= {19'h00000, next_pc_reg};
            else if (paddr == `EBC_OFF_IRQ_STAT)
                prdata_reg <= {30'h00000000, irq_stat_reg};
            else if (paddr == `EBC_OFF_IRQ_MASK)
                prdata_reg <= {30'h00000000, irq_mask_reg};
            else
                prdata_reg <= 32'h0000_0000;
        end
    end
endmodule // ebc_break_unit
`default_nettype wire

// *** logic/ebc_map.vh ***
// Purpose: Constants for the emulation break and cycle counter block.
// Assumes: APB slave, 32-bit data, word-aligned registers.
// Notes: Offsets are byte addresses.
`ifndef EBC_MAP_VH
`define EBC_MAP_VH
`define EBC_OFF_CTRL 12'h000
`define EBC_OFF_CAUSE 12'h004
`define EBC_OFF_CYC 12'h008
`define EBC_OFF_START 12'h00c
`define EBC_OFF_STOP 12'h010
`define EBC_OFF_BPADDR 12'h014
`define EBC_OFF_BPDATA 12'h018
`define EBC_OFF_CMADDR 12'h01c
`define EBC_OFF_CMDATA 12'h020
`define EBC_OFF_BRKPC 12'h024
`define EBC_OFF_NEXTPC 12'h028
`define EBC_OFF_IRQ_STAT 12'h02c
`define EBC_OFF_IRQ_MASK 12'h030
`define EBC_OFF_BPFILL 12'h034
// Control register fields.
`define EBC_CTRL_EN_BP 0
`define EBC_CTRL_EN_TP 1
`define EBC_CTRL_EN_CC 2
`define EBC_CTRL_MODE_LO 4
`define EBC_CTRL_RUN 8
`define EBC_CTRL_RESET 32'h0000_0000
// Code space tops per chip mode.
`define EBC_TOP_MODE0 13'h07df
`define EBC_TOP_MODE1 13'h0fdf
`define EBC_TOP_MODE2 13'h1fdf
`define EBC_CODE_WORDS 8192
// Break cause codes.
`define EBC_CAUSE_NONE 4'h0
`define EBC_CAUSE_ESC 4'h1
`define EBC_CAUSE_BP 4'h2
`define EBC_CAUSE_TPOVF 4'h3
`define EBC_CAUSE_CCOVF 4'h4
`define EBC_CAUSE_AMATCH 4'h5
`define EBC_CAUSE_APASS 4'h6
`define EBC_CAUSE_DPASS 4'h7
`define EBC_CAUSE_BAPASS 4'h8
`define EBC_CAUSE_NAREA 4'h9
`endif

// *** logic/ebc_cycle_counter.v ***
// Purpose: Cycle counter gated by start and stop addresses.
// Assumes: Fetch strobe marks the first byte of an executed instruction.
// Notes: Counter wraps past all ones and flags the wrap with a one-cycle pulse.
`default_nettype none
module ebc_cycle_counter (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Core stream.
    input wire run,
    input wire halt,
    input wire fetch,
    input wire [12:0] fetch_addr,
    input wire clear,
    // Trigger addresses.
    input wire [12:0] start_addr,
    input wire [12:0] stop_addr,
    // Results.
    output reg [31:0] count_reg,
    output reg overflow_pulse
);
    reg active_reg;

    // Counting opens at the start address and closes at the stop address.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reg <= 1'b0;
            count_reg <= 32'h0000_0000;
            overflow_pulse <= 1'b0;
        end else begin
            overflow_pulse <= 1'b0;
            if (clear) begin
                active_reg <= 1'b0;
                count_reg <= 32'h0000_0000;
            end else begin
                if (run && fetch && fetch_addr == start_addr)
                    active_reg <= 1'b1;
                else if (run && fetch && fetch_addr == stop_addr)
                    active_reg <= 1'b0;
                // Halt freezes the count so sleep time does not skew figures.
                if (run && active_reg && !halt) begin
                    count_reg <= count_reg + 32'h0000_0001;
                    if (count_reg == 32'hffff_ffff)
                        overflow_pulse <= 1'b1;
                end
            end
        end
    end
endmodule // ebc_cycle_counter
`default_nettype wire

// *** verif/ebc_core_model.sv ***
// Purpose: Emulated core fetch stream.
// Assumes: Two-byte instructions, one fetch per running cycle.
// Notes: Halt freezes fetching, so slow cores are made with halt.
`default_nettype none
module ebc_core_model (
    // Clock and control.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [12:0] start_pc,
    input wire logic emu_run,
    input wire logic halt_mode,
    // Fetch stream.
    output logic fetch_first,
    output logic [12:0] fetch_pc,
    output logic [12:0] next_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only first bytes are flagged, so odd bytes never see a strobe.
    assign fetch_first = emu_run && !halt_mode;
    assign next_pc = fetch_pc + 13'h0002;
    // Step through the program while running.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) fetch_pc <= 13'h0000;
        else if (load) fetch_pc <= start_pc;
        else if (fetch_first) fetch_pc <= next_pc;
    end
endmodule // ebc_core_model
`default_nettype wire

// *** verif/ebc_break_unit_asserts.sv ***
// Purpose: Port checks for the break unit.
// Assumes: Bound to every ebc_break_unit.
// Notes: Mode is not visible here, so only the widest top is used.
`default_nettype none
module ebc_break_unit_asserts (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Core stream and control.
    input wire logic fetch_first,
    input wire logic [12:0] fetch_pc,
    input wire logic esc_req,
    input wire logic addr_match_brk,
    input wire logic emu_run,
    input wire logic emu_stop
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus phases.
    sequence s_rd_setup; psel && !penable && !pwrite; endsequence
    sequence s_access; psel && penable; endsequence
    property p_read_no_wait; s_rd_setup ##1 s_access |-> pready; endproperty
    property p_no_slverr; !pslverr; endproperty
    property p_stop_halts; emu_stop |-> !emu_run; endproperty
    property p_stop_pulse; emu_stop |=> !emu_stop; endproperty
    property p_stop_from_run; emu_stop |-> $past(emu_run); endproperty
    property p_esc_stops; esc_req && emu_run |=> emu_stop; endproperty
    property p_match_stops; addr_match_brk && emu_run |=> emu_stop; endproperty
    property p_top_stops; fetch_first && emu_run && fetch_pc > 13'h1fdf |=> emu_stop;
    endproperty
    a_read_no_wait: assert property (p_read_no_wait)
        else $error("read waited");
    a_no_slverr: assert property (p_no_slverr) else $error("slave error");
    a_stop_halts: assert property (p_stop_halts) else $error("run after stop");
    a_stop_pulse: assert property (p_stop_pulse) else $error("long stop");
    a_stop_from_run: assert property (p_stop_from_run)
        else $error("stop while idle");
    a_esc_stops: assert property (p_esc_stops) else $error("escape missed");
    a_match_stops: assert property (p_match_stops) else $error("match missed");
    a_top_stops: assert property (p_top_stops) else $error("range missed");
endmodule // ebc_break_unit_asserts
bind ebc_break_unit ebc_break_unit_asserts i_ebc_break_unit_asserts (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .fetch_first(fetch_first), .fetch_pc(fetch_pc),
    .esc_req(esc_req), .addr_match_brk(addr_match_brk), .emu_run(emu_run),
    .emu_stop(emu_stop));
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the break unit.
// Assumes: APB master waits for pready, however long.
// Notes: A window of eight fetches, one per cycle, gives an exact count with or without halt.
`include "ebc_map.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic halt_mode = 1'b0;
    logic load = 1'b0;
    logic [12:0] start_pc = 13'h0;
    logic [5:0] evt = 6'h0;
    logic [31:0] prdata, q, c1;
    logic pready, pslverr, fetch_first, emu_run, emu_stop, irq;
    logic [12:0] fetch_pc, next_pc;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    // Core partner and unit.
    ebc_core_model i_ebc_core_model (.pclk(pclk), .presetn(presetn), .load(load),
        .start_pc(start_pc), .emu_run(emu_run), .halt_mode(halt_mode),
        .fetch_first(fetch_first), .fetch_pc(fetch_pc), .next_pc(next_pc));
    ebc_break_unit i_ebc_break_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_first(fetch_first),
        .fetch_pc(fetch_pc), .next_pc(next_pc), .halt_mode(halt_mode), .esc_req(evt[0]),
        .trace_overflow(evt[1]), .addr_match_brk(evt[2]), .addr_pass_brk(evt[3]),
        .data_pass_brk(evt[4]), .acc_pass_brk(evt[5]), .emu_run(emu_run),
        .emu_stop(emu_stop), .irq(irq));
    initial begin
        forever #4 pclk = ~pclk;
    end
    // A hang counts as a mismatch.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; a spare edge after release keeps drivers from colliding.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, e);
    endtask
    task automatic go(input logic [12:0] pc, input logic [31:0] ctrl);
        start_pc <= pc;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        wr(`EBC_OFF_CTRL, ctrl);
    endtask
    task automatic pulse(input int i);
        evt <= 6'h01 << i;
        @(posedge pclk);
        evt <= 6'h00;
    endtask
    task automatic wait_pc(input logic [12:0] pc);
        for (int n = 0; n < 200 && fetch_pc !== pc; n++) @(posedge pclk);
    endtask
    task automatic wait_stop;
        for (int n = 0; n < 300 && emu_stop !== 1'b1; n++) @(posedge pclk);
        chk("stop", {31'h0, emu_stop}, 32'h1);
        @(posedge pclk);
    endtask
    task automatic t_reset;
        rdc(`EBC_OFF_CAUSE, {28'h0, `EBC_CAUSE_NONE});
        rdc(`EBC_OFF_CTRL, `EBC_CTRL_RESET);
        rdc(12'h03c, 32'h0);
    endtask
    task automatic t_code;
        logic [12:0] top [3] = '{`EBC_TOP_MODE0, `EBC_TOP_MODE1, `EBC_TOP_MODE2};
        for (int m = 0; m < 3; m++) begin
            wr(`EBC_OFF_CTRL, {26'h0, m[1:0], 4'h0});
            wr(`EBC_OFF_BPADDR, {19'h0, top[m]});
            wr(`EBC_OFF_BPDATA, 32'h1);
            rdc(`EBC_OFF_BPDATA, 32'h1);
            wr(`EBC_OFF_CMADDR, {19'h0, top[m]});
            wr(`EBC_OFF_CMDATA, 32'h5a + 32'(m));
            rdc(`EBC_OFF_CMDATA, 32'h5a + 32'(m));
            wr(`EBC_OFF_CMADDR, {19'h0, top[m] + 13'h1});
            wr(`EBC_OFF_CMDATA, 32'ha5);
            rdc(`EBC_OFF_CMDATA, 32'h0);
        end
    endtask
    task automatic t_bp;
        // Clear every bit first so no unwritten bit can stop a run.
        wr(`EBC_OFF_BPFILL, 32'h0);
        wr(`EBC_OFF_BPADDR, 32'h1fdf);
        rdc(`EBC_OFF_BPDATA, 32'h0);
        wr(`EBC_OFF_BPADDR, 32'h1f);
        wr(`EBC_OFF_BPDATA, 32'h1);
        wr(`EBC_OFF_BPADDR, 32'h24);
        wr(`EBC_OFF_BPDATA, 32'h1);
        go(13'h1a, 32'h121);
        wait_stop();
        rdc(`EBC_OFF_CAUSE, {28'h0, `EBC_CAUSE_BP});
        rdc(`EBC_OFF_BRKPC, 32'h24);
        rdc(`EBC_OFF_NEXTPC, 32'h26);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`EBC_OFF_IRQ_MASK, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(`EBC_OFF_IRQ_STAT, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
    endtask
    // Enables clear: a set bit and a trace overflow pass by until the top.
    task automatic t_range;
        wr(`EBC_OFF_BPADDR, 32'h1fdc);
        wr(`EBC_OFF_BPDATA, 32'h1);
        go(13'h1fd6, 32'h120);
        pulse(1);
        wait_stop();
        rdc(`EBC_OFF_CAUSE, {28'h0, `EBC_CAUSE_NAREA});
    endtask
    task automatic t_causes;
        logic [3:0] cz [6] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};
        for (int i = 0; i < 6; i++) begin
            go(13'h0, 32'h106);
            pulse(i);
            wait_stop();
            rdc(`EBC_OFF_CAUSE, {28'h0, cz[i]});
        end
    endtask
    task automatic t_count;
        wr(`EBC_OFF_START, 32'h40);
        wr(`EBC_OFF_STOP, 32'h50);
        for (int k = 0; k < 2; k++) begin
            go(13'h30, 32'h100);
            wait_pc(13'h48);
            halt_mode <= k[0];
            repeat (4) @(posedge pclk);
            halt_mode <= 1'b0;
            wait_pc(13'h60);
            pulse(0);
            wait_stop();
            xfer(1'b0, `EBC_OFF_CYC, 32'h0);
            if (k == 0) c1 = q;
        end
        chk("span", c1, 32'h8);
        chk("halted count", q, 32'h8);
        rdc(`EBC_OFF_START, 32'h40);
        rdc(`EBC_OFF_STOP, 32'h50);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_code();
        t_bp();
        t_range();
        t_causes();
        t_count();
        conclude();
    end
endmodule // tb
`default_nettype wire
